// [verilog/crd_card.sv]
// card end: command decode and read data transmit on the data lines
`timescale 1ns/100ps
module crd_card
    import crd_pkg::*;
#(
    parameter logic [31:0] MEM_BYTES = 32'h0010_0000,
    parameter int          FIFO_D    = 32
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    crd_link_if.card         lnk,
    input  wire logic        partial_en,
    input  wire logic        misalign_en,
    input  wire logic        fill_valid,
    input  wire logic [7:0]  fill_data,
    output logic             fill_ready,
    output logic [31:0]      fetch_addr,
    output logic             fetch_busy,
    output logic [7:0]       status,
    output logic [1:0]       bus_width
);
    import crd_pkg::*;

    typedef struct packed {
        logic [2:0]       lc;
        logic [1:0]       cs;
        logic             cmd_on;
        logic [5:0]       cbit;
        logic [38:0]      csh;
        crd_cst_t         st;
        logic             stream;
        logic             single;
        logic             counted;
        logic             precount;
        logic [15:0]      bcnt;
        logic [1:0]       width;
        logic [9:0]       blen;
        logic [9:0]       left;
        logic [31:0]      addr;
        logic [7:0]       sh;
        logic [3:0]       bitn;
        logic [3:0]       crcn;
        logic [7:0][15:0] crc;
        logic [7:0]       err;
        logic [7:0]       dat;
        logic [7:0]       oe_n;
        logic             resp;
        logic [9:0]       rsh;
        logic [3:0]       rn;
        logic [7:0]       status;
        logic             flush;
        logic             busy;
    } crd_card_t;

    localparam crd_card_t RST = '{st: C_TRAN, width: WIDTH_RST, blen: 10'(SECTOR),
                                  dat: 8'hFF, oe_n: 8'hFF, resp: 1'b1, default: '0};

    crd_card_t   s;
    crd_card_t   next_s;
    logic        rise;
    logic        fall;
    logic        dec;
    logic        pop;
    logic        f_valid;
    logic [7:0]  f_data;
    logic [38:0] frame;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic [7:0]  rs;
    logic [7:0]  cur;
    logic [7:0]  out;
    logic [7:0]  mask;
    logic [3:0]  step;
    logic [3:0]  nb;
    logic        oor;
    logic        blen_ok;
    logic        mis;
    logic        mis_next;
    logic        fb;

    initial begin
        if (SECTOR >= 1024) $error("block length field too narrow for sector");
        if (FIFO_D < 2) $error("fetch buffer too shallow");
    end

    crd_fifo #(.W(BYTE_BITS), .D(FIFO_D)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (s.flush),
        .in_valid  (fill_valid),
        .in_data   (fill_data),
        .in_ready  (fill_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (pop)
    );

    always_comb begin
        next_s = s;
        next_s.lc = {s.lc[1:0], lnk.link_clk};
        next_s.cs = {s.cs[0], lnk.cmd};
        next_s.flush = 1'b0;
        rise = !s.lc[2] && s.lc[1];
        fall = s.lc[2] && !s.lc[1];
        frame = {s.csh[37:0], s.cs[1]};
        idx = frame[38:33];
        arg = frame[32:1];
        dec = 1'b0;
        pop = 1'b0;
        rs = '0;
        fb = 1'b0;
        mask = crd_mask(s.width);
        step = crd_step(s.width);
        nb = s.bitn + step;
        cur = (s.bitn == '0) ? f_data : s.sh;
        out = (s.width == W8) ? cur : (s.width == W4) ? {4'hF, cur[7:4]} : {7'h7F, cur[7]};
        oor = (arg >= MEM_BYTES);
        blen_ok = (s.blen == 10'(SECTOR)) || (partial_en && s.blen != '0);
        mis = !misalign_en && ((arg & 32'(SECTOR - 1)) + 32'(s.blen) > 32'(SECTOR));
        mis_next = !misalign_en && ((s.addr & 32'(SECTOR - 1)) + 32'(s.blen) > 32'(SECTOR));

        // data lines change on the bus clock falling edge
        if (fall) begin
            case (s.st)
                C_BSTART: begin
                    if (f_valid) begin
                        next_s.dat = 8'h00;
                        next_s.oe_n = ~mask;
                        next_s.st = s.stream ? C_STREAM : C_BDATA;
                        next_s.bitn = '0;
                        next_s.left = s.blen;
                        next_s.crc = '0;
                    end
                end
                C_STREAM: begin
                    // bits past memory end or underrun are don't-care, held high
                    if (s.addr >= MEM_BYTES) begin
                        next_s.err[ST_OOR] = 1'b1;
                        next_s.dat = 8'hFF;
                    end else if (s.bitn == '0 && !f_valid) begin
                        next_s.err[ST_UNDER] = 1'b1;
                        next_s.dat = 8'hFF;
                    end else begin
                        next_s.dat = out;
                        next_s.sh = cur << 1;
                        pop = (s.bitn == '0);
                        next_s.bitn = (nb == 4'(BYTE_BITS)) ? '0 : nb;
                        if (nb == 4'(BYTE_BITS)) next_s.addr = s.addr + 32'h1;
                    end
                end
                C_BDATA: begin
                    if (s.bitn == '0 && !f_valid) begin
                        next_s.err[ST_UNDER] = 1'b1;
                        next_s.st = C_HOLD;
                        next_s.dat = 8'hFF;
                        next_s.oe_n = 8'hFF;
                    end else begin
                        next_s.dat = out;
                        next_s.sh = cur << step;
                        pop = (s.bitn == '0);
                        for (int i = 0; i < 8; i++) begin
                            fb = s.crc[i][15] ^ out[i];
                            if (mask[i]) next_s.crc[i] = {s.crc[i][14:0], 1'b0} ^
                                                         (fb ? CRC_POLY : 16'h0000);
                        end
                        next_s.bitn = (nb == 4'(BYTE_BITS)) ? '0 : nb;
                        if (nb == 4'(BYTE_BITS)) begin
                            next_s.addr = s.addr + 32'h1;
                            next_s.left = s.left - 10'h1;
                            if (s.left == 10'h1) begin
                                next_s.st = C_BCRC;
                                next_s.crcn = '0;
                            end
                        end
                    end
                end
                C_BCRC: begin
                    for (int i = 0; i < 8; i++) begin
                        next_s.dat[i] = s.crc[i][15];
                        next_s.crc[i] = s.crc[i] << 1;
                    end
                    next_s.crcn = s.crcn + 4'h1;
                    if (s.crcn == 4'(CRC_BITS - 1)) next_s.st = C_BEND;
                end
                C_BEND: begin
                    next_s.dat = 8'hFF;
                    if (s.single || (s.counted && s.bcnt == 16'h1)) begin
                        next_s.st = C_TRAN;
                    end else begin
                        next_s.bcnt = s.bcnt - 16'h1;
                        next_s.st = C_BSTART;
                        if (s.addr >= MEM_BYTES) begin
                            next_s.err[ST_OOR] = 1'b1;
                            next_s.st = C_HOLD;
                        end else if (mis_next) begin
                            next_s.err[ST_MIS] = 1'b1;
                            next_s.st = C_HOLD;
                        end
                    end
                end
                default: begin
                    next_s.dat = 8'hFF;
                    next_s.oe_n = 8'hFF;
                end
            endcase
            if (s.rn != '0) begin
                next_s.resp = s.rsh[9];
                next_s.rsh = s.rsh << 1;
                next_s.rn = s.rn - 4'h1;
            end else begin
                next_s.resp = 1'b1;
            end
        end

        // command bits are sampled on the rising edge
        if (rise) begin
            if (!s.cmd_on) begin
                next_s.cmd_on = !s.cs[1];
                next_s.cbit = '0;
            end else begin
                next_s.csh = frame;
                next_s.cbit = s.cbit + 6'h1;
                if (s.cbit == 6'(CMD_BITS - 2)) begin
                    next_s.cmd_on = 1'b0;
                    dec = frame[0];
                end
            end
        end

        if (dec) begin
            next_s.precount = (idx == CMD_COUNT);
            case (idx)
                CMD_STOP: begin
                    if (s.st != C_TRAN) begin
                        rs = s.err;
                        next_s.err = '0;
                        next_s.st = C_TRAN;
                    end else begin
                        rs[ST_ILL] = 1'b1;
                    end
                end
                CMD_STREAM: begin
                    if (s.st != C_TRAN || s.width != W1) rs[ST_ILL] = 1'b1;
                    else if (oor) rs[ST_OOR] = 1'b1;
                    else next_s.stream = 1'b1;
                end
                CMD_SINGLE, CMD_MULTI: begin
                    if (s.st != C_TRAN) rs[ST_ILL] = 1'b1;
                    else if (oor) rs[ST_OOR] = 1'b1;
                    else if (!blen_ok) rs[ST_BLEN] = 1'b1;
                    else if (mis) rs[ST_MIS] = 1'b1;
                    else next_s.stream = 1'b0;
                    next_s.single = (idx == CMD_SINGLE);
                    next_s.counted = s.precount && s.bcnt != '0;
                end
                CMD_COUNT: next_s.bcnt = arg[15:0];
                CMD_BLKLEN: next_s.blen = (arg > 32'(SECTOR)) ? '0 : arg[9:0];
                CMD_WIDTH: begin
                    if (arg[1:0] == W1 || arg[1:0] == W4 || arg[1:0] == W8) begin
                        next_s.width = arg[1:0];
                    end else begin
                        rs[ST_ILL] = 1'b1;
                    end
                end
                default: rs[ST_ILL] = 1'b1;
            endcase
            if ((idx == CMD_STREAM || idx == CMD_SINGLE || idx == CMD_MULTI) && rs == '0) begin
                next_s.st = C_BSTART;
                next_s.addr = arg;
                next_s.flush = 1'b1;
                next_s.err = '0;
            end
            next_s.status = rs;
            next_s.rsh = {1'b0, rs, 1'b1};
            next_s.rn = 4'(RESP_BITS);
        end
        next_s.busy = (next_s.st != C_TRAN) && (next_s.st != C_HOLD);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) s <= RST;
        else s <= next_s;
    end

    assign lnk.dat_o = s.dat;
    assign lnk.dat_oe_n = s.oe_n;
    assign lnk.resp = s.resp;
    assign fetch_addr = s.addr;
    assign fetch_busy = s.busy;
    assign status = s.status;
    assign bus_width = s.width;
endmodule : crd_card

// [verilog/crd_pkg.sv]
// shared constants and types for the card read data link
package crd_pkg;
    localparam int          CLK_NS        = 4;
    localparam int          LINK_NS       = 48;
    localparam int          LINK_HALF_CYC = LINK_NS / (2 * CLK_NS);
    localparam int          SECTOR        = 512;
    localparam int          CMD_BITS      = 40;
    localparam int          RESP_BITS     = 10;
    localparam int          CRC_BITS      = 16;
    localparam int          BYTE_BITS     = 8;
    localparam logic [15:0] CRC_POLY      = 16'h1021;
    localparam logic [5:0]  CMD_WIDTH     = 6'h06;
    localparam logic [5:0]  CMD_STREAM    = 6'h0B;
    localparam logic [5:0]  CMD_STOP      = 6'h0C;
    localparam logic [5:0]  CMD_BLKLEN    = 6'h10;
    localparam logic [5:0]  CMD_SINGLE    = 6'h11;
    localparam logic [5:0]  CMD_MULTI     = 6'h12;
    localparam logic [5:0]  CMD_COUNT     = 6'h17;
    localparam logic [1:0]  W1            = 2'h0;
    localparam logic [1:0]  W4            = 2'h1;
    localparam logic [1:0]  W8            = 2'h2;
    localparam logic [1:0]  WIDTH_RST     = W1;
    localparam int          ST_OOR        = 7;
    localparam int          ST_MIS        = 6;
    localparam int          ST_BLEN       = 5;
    localparam int          ST_ILL        = 4;
    localparam int          ST_UNDER      = 3;

    typedef enum logic [2:0] {C_TRAN, C_BSTART, C_STREAM, C_BDATA, C_BCRC, C_BEND,
                              C_HOLD} crd_cst_t;
    typedef enum logic [1:0] {H_IDLE, H_DATA, H_CRC, H_END} crd_hst_t;

    function automatic logic [7:0] crd_mask(input logic [1:0] w);
        crd_mask = (w == W8) ? 8'hFF : (w == W4) ? 8'h0F : 8'h01;
    endfunction : crd_mask

    function automatic logic [3:0] crd_step(input logic [1:0] w);
        crd_step = (w == W8) ? 4'h8 : (w == W4) ? 4'h4 : 4'h1;
    endfunction : crd_step
endpackage : crd_pkg

// [verilog/crd_link_if.sv]
// pins between host and card: bus clock, command, response, data lines
`timescale 1ns/100ps
interface crd_link_if;
    logic       link_clk;
    logic       cmd;
    logic       resp;
    logic [7:0] dat_o;
    logic [7:0] dat_oe_n;
    logic [7:0] dat;

    // released lines float high through the pull-ups
    assign dat = dat_o | dat_oe_n;

    modport card (input link_clk, input cmd, output resp, output dat_o, output dat_oe_n);
    modport host (output link_clk, output cmd, input resp, input dat);
endinterface : crd_link_if

// [verilog/crd_fifo.sv]
// fetch buffer between memory side and the data line serialiser
`timescale 1ns/100ps
module crd_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic                full;
    } crd_fifo_t;

    crd_fifo_t s;
    crd_fifo_t next_s;
    logic      push;
    logic      pop;

    initial begin
        if (D < 2 || (1 << AW) != D) $error("depth must be a power of two");
    end

    always_comb begin
        next_s = s;
        push = in_valid && !s.full;
        pop = out_ready && (s.cnt != '0);
        if (push) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) next_s.rp = s.rp + 1'b1;
        next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        // flush drops what the previous read queued; a word pushed in the same
        // cycle already belongs to the new read, so it is kept at the head
        if (flush) begin
            next_s.rp = '0;
            next_s.wp = AW'(push);
            next_s.cnt = (AW + 1)'(push);
            if (push) next_s.mem[0] = in_data;
        end
        next_s.full = (next_s.cnt == (AW + 1)'(D));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) s <= '0;
        else s <= next_s;
    end

    assign in_ready = !s.full;
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];
endmodule : crd_fifo

// [verilog/crd_host.sv]
// host end: bus clock divider, command sender, response and data receiver
`timescale 1ns/100ps
module crd_host
    import crd_pkg::*;
#(
    parameter int HALF = LINK_HALF_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    crd_link_if.host        lnk,
    input  wire logic       cmd_valid,
    input  wire logic [5:0] cmd_index,
    input  wire logic [31:0] cmd_arg,
    output logic            cmd_ready,
    output logic            resp_valid,
    output logic [7:0]      resp_status,
    input  wire logic [1:0] rx_width,
    input  wire logic       rx_block,
    input  wire logic [9:0] rx_blen,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_end_err
);
    import crd_pkg::*;

    typedef struct packed {
        logic [7:0]  cnt;
        logic        lclk;
        logic        cmd;
        logic [39:0] csh;
        logic [5:0]  cn;
        logic        crdy;
        logic [1:0]  rs;
        logic        ron;
        logic [3:0]  rn;
        logic [7:0]  rsh;
        logic        rv;
        logic [7:0]  rstat;
        logic [7:0]  d1;
        logic [7:0]  d2;
        crd_hst_t    st;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic [9:0]  left;
        logic [3:0]  crcn;
        logic        xv;
        logic [7:0]  xd;
        logic        xerr;
    } crd_host_t;

    localparam crd_host_t RST = '{st: H_IDLE, cmd: 1'b1, crdy: 1'b1, rs: 2'h3,
                                  d1: 8'hFF, d2: 8'hFF, default: '0};

    crd_host_t  s;
    crd_host_t  next_s;
    logic       tick;
    logic       smp;
    logic [3:0] nb;
    logic [7:0] shv;
    logic [7:0] mask;

    // card needs a few cycles to see our edges and answer before we sample
    initial begin
        if (HALF < 4 || HALF > 255) $error("bus clock half period out of range");
    end

    always_comb begin
        next_s = s;
        next_s.rv = 1'b0;
        next_s.xv = 1'b0;
        next_s.xerr = 1'b0;
        next_s.d1 = lnk.dat;
        next_s.d2 = s.d1;
        next_s.rs = {s.rs[0], lnk.resp};
        mask = crd_mask(rx_width);
        nb = s.bitn + crd_step(rx_width);
        shv = (rx_width == W8) ? s.d2 :
              (rx_width == W4) ? {s.sh[3:0], s.d2[3:0]} : {s.sh[6:0], s.d2[0]};
        tick = (s.cnt == 8'(HALF - 1));
        smp = s.lclk && (s.cnt == 8'(HALF - 2));
        next_s.cnt = tick ? '0 : s.cnt + 8'h1;
        // slow half period keeps stream reads clear of underrun
        if (tick) begin
            next_s.lclk = !s.lclk;
            if (s.lclk && s.cn != '0) begin
                next_s.cmd = s.csh[39];
                next_s.csh = s.csh << 1;
                next_s.cn = s.cn - 6'h1;
            end
        end
        // commands leave in user order, so count-then-read and stop follow it
        if (cmd_valid && s.crdy) begin
            next_s.csh = {1'b0, cmd_index, cmd_arg, 1'b1};
            next_s.cn = 6'(CMD_BITS);
        end
        next_s.crdy = (next_s.cn == '0);

        if (smp) begin
            if (!s.ron) begin
                next_s.ron = !s.rs[1];
                next_s.rn = '0;
            end else if (s.rn == 4'(BYTE_BITS)) begin
                next_s.ron = 1'b0;
                next_s.rv = 1'b1;
                next_s.rstat = s.rsh;
            end else begin
                next_s.rsh = {s.rsh[6:0], s.rs[1]};
                next_s.rn = s.rn + 4'h1;
            end
            case (s.st)
                H_IDLE: begin
                    if (!s.d2[0]) begin
                        next_s.st = H_DATA;
                        next_s.bitn = '0;
                        next_s.left = rx_blen;
                    end
                end
                H_DATA: begin
                    next_s.sh = shv;
                    next_s.bitn = (nb == 4'(BYTE_BITS)) ? '0 : nb;
                    if (nb == 4'(BYTE_BITS)) begin
                        next_s.xv = 1'b1;
                        next_s.xd = shv;
                        if (rx_block) begin
                            next_s.left = s.left - 10'h1;
                            if (s.left == 10'h1) begin
                                next_s.st = H_CRC;
                                next_s.crcn = '0;
                            end
                        end
                    end
                end
                H_CRC: begin
                    next_s.crcn = s.crcn + 4'h1;
                    if (s.crcn == 4'(CRC_BITS - 1)) next_s.st = H_END;
                end
                H_END: begin
                    next_s.xerr = ((s.d2 & mask) != mask);
                    next_s.st = H_IDLE;
                end
                default: next_s.st = H_IDLE;
            endcase
        end
        // the stop answer closes a stream, which has no end bit
        if (s.rv && !rx_block) next_s.st = H_IDLE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) s <= RST;
        else s <= next_s;
    end

    assign lnk.link_clk = s.lclk;
    assign lnk.cmd = s.cmd;
    assign cmd_ready = s.crdy;
    assign resp_valid = s.rv;
    assign resp_status = s.rstat;
    assign rx_valid = s.xv;
    assign rx_data = s.xd;
    assign rx_end_err = s.xerr;
endmodule : crd_host

// [dv/crd_link_chk.sv]
// wire-level checks on the host/card link
`timescale 1ns/100ps
module crd_link_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       link_clk,
    input wire logic       cmd,
    input wire logic       resp,
    input wire logic [7:0] dat_o,
    input wire logic [7:0] dat_oe_n,
    input wire logic [7:0] dat
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus clock high phase of six cycles
    sequence s_high_run;
        link_clk [*5];
    endsequence
    a_rst_lines_idle: assert property ($rose(rst_n) |-> dat_oe_n == 8'hFF && cmd && resp)
        else $error("link not idle after reset");
    a_idle_lines_high: assert property (&dat_oe_n |-> dat_o == 8'hFF)
        else $error("released data lines not high");
    a_start_bit_low: assert property ($fell(dat_oe_n[0]) |-> !dat_o[0])
        else $error("frame opened without low start bit");
    a_lane_set_legal: assert property (dat_oe_n inside {8'hFF, 8'hFE, 8'hF0, 8'h00})
        else $error("driven lanes match no bus width");
    a_dat_on_fall: assert property ($changed(dat_o) |-> !link_clk)
        else $error("data changed while bus clock high");
    a_resp_on_fall: assert property ($changed(resp) |-> !link_clk)
        else $error("response changed while bus clock high");
    a_cmd_on_fall: assert property ($changed(cmd) |-> !link_clk)
        else $error("command changed while bus clock high");
    a_clk_half_len: assert property ($rose(link_clk) |=> s_high_run)
        else $error("bus clock high phase too short");
endmodule : crd_link_chk

// [dv/test_card_read_data_path.sv]
// self-checking bench: host and card ends joined over the link
`timescale 1ns/100ps
module test_card_read_data_path;
    import crd_pkg::*;
    logic        clk = 0, rst_n = 0, partial_en = 1, fill_valid = 0, cmd_valid = 0;
    logic [7:0]  fill_data = 8'h00;
    logic [5:0]  cmd_index = 6'h00;
    logic [31:0] cmd_arg = 32'h0;
    logic        fill_ready, fetch_busy, cmd_ready, resp_valid, rx_valid, rx_end_err;
    logic [7:0]  resp_status, rx_data;
    logic [7:0]  exp_d[$], exp_s[$];
    int          err_count = 0, tests_run = 0, fill_left = 0, cyc = 0;
    crd_link_if lnk();
    crd_card #(.MEM_BYTES(32'h0000_1000)) crd_card_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
        .partial_en(partial_en), .misalign_en(1'b0), .fill_valid(fill_valid),
        .fill_data(fill_data), .fill_ready(fill_ready), .fetch_addr(), .fetch_busy(fetch_busy),
        .status(), .bus_width());
    crd_host crd_host_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk), .cmd_valid(cmd_valid),
        .cmd_index(cmd_index), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_status(resp_status), .rx_width(W1), .rx_block(1'b1), .rx_blen(10'h008),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end_err(rx_end_err));
    crd_link_chk crd_link_chk_inst (.clk(clk), .rst_n(rst_n), .link_clk(lnk.link_clk),
        .cmd(lnk.cmd), .resp(lnk.resp), .dat_o(lnk.dat_o), .dat_oe_n(lnk.dat_oe_n), .dat(lnk.dat));
    always #2 clk = ~clk;
    task automatic results;
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    // one command at a time: hold until taken, then wait for its response
    task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic [7:0] st);
        exp_s.push_back(st);
        @(negedge clk);
        cmd_valid = 1;
        cmd_index = idx;
        cmd_arg = arg;
        @(posedge clk);
        while (!cmd_ready) @(posedge clk);
        @(negedge clk);
        cmd_valid = 0;
        while (exp_s.size() != 0) @(negedge clk);
    endtask : send
    task automatic rd(input logic [5:0] idx, input logic [31:0] arg, input int n);
        fill_left = n;
        send(idx, arg, 8'h00);
        while (fill_left != 0 || exp_d.size() != 0) @(negedge clk);
    endtask : rd
    // fill only while sending: earlier bytes are flushed by the card
    always @(negedge clk) begin
        if (!fill_valid && fetch_busy && fill_left > 0) begin
            fill_data = 8'($urandom);
            fill_valid = 1;
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (fill_valid && fill_ready) begin
            exp_d.push_back(fill_data);
            fill_left--;
            fill_valid <= 0;
        end
        if (rx_valid) chk("rx_data", exp_d.size() ? exp_d.pop_front() : 8'hEE, rx_data);
        if (resp_valid) chk("status", exp_s.size() ? exp_s.pop_front() : 8'hEE, resp_status);
        if (rx_end_err) chk("rx_end_err", 8'h00, 8'h01);
        if (cyc == 60000) begin
            err_count++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h3180AEBE));
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        send(CMD_BLKLEN, 32'h8, 8'h00);
        rd(CMD_SINGLE, 32'h10, 8);
        send(CMD_COUNT, 32'h2, 8'h00);
        rd(CMD_MULTI, 32'h20, 16);
        send(CMD_STOP, 32'h0, 8'h10);
        send(CMD_SINGLE, 32'h1000, 8'h80);
        send(CMD_MULTI, 32'h1FC, 8'h40);
        partial_en = 0;
        send(CMD_SINGLE, 32'h0, 8'h20);
        partial_en = 1;
        send(CMD_WIDTH, 32'h1, 8'h00);
        send(CMD_STREAM, 32'h0, 8'h10);
        send(CMD_WIDTH, 32'h0, 8'h00);
        send(CMD_COUNT, 32'h0, 8'h00);
        rd(CMD_MULTI, 32'h40, 8);
        send(CMD_STOP, 32'h0, 8'h00);
        results();
    end
endmodule : test_card_read_data_path
